// ==== design/pulse_counter_consts.svh ====
// Register offsets, field positions, reset values and timing counts for the pull-up/status block.
`ifndef PULSE_COUNTER_CONSTS_SVH
`define PULSE_COUNTER_CONSTS_SVH

// ==========================================================================
// Register offsets
`define ADDR_COUNTER_STATUS 8'hC1
`define ADDR_PULLUP_CONFIG 8'hD7
`define ADDR_THRESHOLD_CONFIG 8'hE4

// ==========================================================================
// Reset values
`define RST_PULLUP_CONFIG 8'h44
`define RST_THRESHOLD_CONFIG 8'h01
`define RST_COUNTER_STATUS 8'h00

// ==========================================================================
// Pull-up configuration fields
`define PCF_CAL_START 7
`define PCF_CAL_RESULT 6
`define PCF_CAL_PORT 5
`define PCF_STRENGTH_HI 4
`define PCF_STRENGTH_LO 2
`define PCF_DUTY_HI 1
`define PCF_DUTY_LO 0
`define CAL_FAIL_LOAD 5'h1F

// ==========================================================================
// Threshold configuration fields
`define TH_HIGH_HI 7
`define TH_HIGH_LO 6
`define TH_LOW_HI 5
`define TH_LOW_LO 4
`define TH_FORCE_PD 3
`define TH_FORCE_PU 2
`define TH_READ_OK 0

// ==========================================================================
// Pull-up strength codes
`define STRENGTH_OFF 3'h0
`define STRENGTH_MIN 3'h1
`define STRENGTH_256UA 3'h5
`define STRENGTH_4MA 3'h7

// ==========================================================================
// Timing
`define CLK_PERIOD_NS 8
`define CAL_SETTLE_NS 1000
`define CAL_SETTLE_CYCLES ((`CAL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DUTY_FRAME_CYCLES 128

`endif

// ==== design/pulse_counter_pkg.sv ====
// Types shared by the pull-up, calibration and status logic.
package pulse_counter_pkg;

   // ==========================================================================
   // Status register layout, bit 7 down to bit 0
   typedef struct packed {
      logic flutter;
      logic direction;
      logic [1:0] fsm_state;
      logic input_b_prior;
      logic input_a_prior;
      logic input_b;
      logic input_a;
   } status_s;

   // ==========================================================================
   // Drive applied to the two pulse inputs
   typedef struct packed {
      logic [2:0] pullup_strength;
      logic pullup_on_a;
      logic pullup_on_b;
      logic pulldown_on;
   } pin_drive_s;

   // ==========================================================================
   // Calibration sequencer states
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_SETTLE = 2'b01,
      CAL_CHECK = 2'b10,
      CAL_DONE = 2'b11
   } cal_state_e;

endpackage

// ==== design/pullup_calibrator.sv ====
// Pull-up calibration sequencer: steps strengths upward until the chosen input reads high.
`timescale 1ns/100ps
`include "pulse_counter_consts.svh"

module pullup_calibrator #(
   parameter int SETTLE_CYCLES = `CAL_SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Control
   input wire logic start,
   input wire logic port_sel,
   // Sensed comparator levels of the pulse inputs
   input wire logic sense_a,
   input wire logic sense_b,
   // Drive and result
   output logic busy,
   output logic [2:0] trial_strength,
   output logic done,
   output logic pass,
   output logic [2:0] found_strength
);

   // ==========================================================================
   // Sequencer
   pulse_counter_pkg::cal_state_e state;
   logic [15:0] settle_count;
   logic sensed;

   assign sensed = port_sel ? sense_b : sense_a;
   assign busy = (state != pulse_counter_pkg::CAL_IDLE);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= pulse_counter_pkg::CAL_IDLE;
         trial_strength <= `STRENGTH_OFF;
         settle_count <= 16'h0000;
         done <= 1'b0;
         pass <= 1'b0;
         found_strength <= `STRENGTH_OFF;
      end else begin
         done <= 1'b0;
         unique case (state)
            pulse_counter_pkg::CAL_IDLE: begin
               if (start) begin
                  // Weakest first, so the first passing code is the lowest usable one.
                  trial_strength <= `STRENGTH_MIN;
                  settle_count <= 16'(SETTLE_CYCLES - 1);
                  state <= pulse_counter_pkg::CAL_SETTLE;
               end
            end
            pulse_counter_pkg::CAL_SETTLE: begin
               if (settle_count == 16'h0000) begin
                  state <= pulse_counter_pkg::CAL_CHECK;
               end else begin
                  settle_count <= settle_count - 16'h0001;
               end
            end
            pulse_counter_pkg::CAL_CHECK: begin
               if (sensed) begin
                  pass <= 1'b1;
                  found_strength <= trial_strength;
                  state <= pulse_counter_pkg::CAL_DONE;
               end else if (trial_strength == `STRENGTH_4MA) begin
                  // A closed switch holds the input low at every strength.
                  pass <= 1'b0;
                  found_strength <= `STRENGTH_4MA;
                  state <= pulse_counter_pkg::CAL_DONE;
               end else begin
                  // Code 6 has no defined strength and is skipped.
                  trial_strength <= (trial_strength == `STRENGTH_256UA) ?
                     `STRENGTH_4MA : trial_strength + 3'h1;
                  settle_count <= 16'(SETTLE_CYCLES - 1);
                  state <= pulse_counter_pkg::CAL_SETTLE;
               end
            end
            pulse_counter_pkg::CAL_DONE: begin
               done <= 1'b1;
               trial_strength <= `STRENGTH_OFF;
               state <= pulse_counter_pkg::CAL_IDLE;
            end
         endcase
      end
   end

endmodule

// ==== design/pulse_counter_pullup_status.sv ====
// Pull-up, threshold, read-valid and status registers of the two-input pulse counter.
`timescale 1ns/100ps
`include "pulse_counter_consts.svh"

module pulse_counter_pullup_status #(
   parameter int SETTLE_CYCLES = `CAL_SETTLE_CYCLES,
   parameter int DUTY_FRAME = `DUTY_FRAME_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Read of a real-time register held elsewhere, and whether it moved meanwhile
   input wire logic ext_rt_rd,
   input wire logic ext_rt_changed,
   // Counter core state
   input wire logic quad_mode,
   input wire logic flutter_raw,
   input wire logic [1:0] fsm_state,
   input wire logic integ_a,
   input wire logic integ_b,
   input wire logic [3:0] rate_duty_num,
   // Comparator levels of the pins, used by calibration
   input wire logic sense_a,
   input wire logic sense_b,
   // Pin drive and comparator selection
   output pulse_counter_pkg::pin_drive_s pin_drive,
   output logic [6:0] high_threshold_pct,
   output logic [6:0] low_threshold_pct,
   output logic [11:0] pullup_na
);

   // ==========================================================================
   // Register storage
   logic cal_start;
   logic cal_result;
   logic cal_port_select;
   logic [2:0] pullup_strength;
   logic [1:0] pullup_duty;
   logic [1:0] high_threshold_sel;
   logic [1:0] low_threshold_sel;
   logic force_pulldown;
   logic force_pullup;
   logic read_ok_flag;
   pulse_counter_pkg::status_s status_now;
   pulse_counter_pkg::status_s status_last;
   logic input_a_prior;
   logic input_b_prior;
   logic direction;
   logic [1:0] pos_last;

   logic wr_pcf;
   logic wr_th;
   logic rd_stat;
   logic rd_th;
   logic cal_busy;
   logic cal_done;
   logic cal_pass;
   logic [2:0] cal_trial;
   logic [2:0] cal_found;
   logic cal_launch;

   assign wr_pcf = sfr_wr && (sfr_addr == `ADDR_PULLUP_CONFIG);
   assign wr_th = sfr_wr && (sfr_addr == `ADDR_THRESHOLD_CONFIG);
   assign rd_stat = sfr_rd && (sfr_addr == `ADDR_COUNTER_STATUS);
   assign rd_th = sfr_rd && (sfr_addr == `ADDR_THRESHOLD_CONFIG);
   assign cal_launch = wr_pcf && sfr_wdata[`PCF_CAL_START] && !cal_start;

   // ==========================================================================
   // Calibration
   pullup_calibrator #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_cal (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .start(cal_launch),
      .port_sel(cal_port_select),
      .sense_a(sense_a),
      .sense_b(sense_b),
      .busy(cal_busy),
      .trial_strength(cal_trial),
      .done(cal_done),
      .pass(cal_pass),
      .found_strength(cal_found)
   );

   // ==========================================================================
   // Pull-up configuration register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cal_start <= 1'(`RST_PULLUP_CONFIG >> `PCF_CAL_START);
         cal_result <= 1'b1;
         cal_port_select <= 1'b0;
         pullup_strength <= `STRENGTH_MIN;
         pullup_duty <= 2'h0;
      end else if (cal_done) begin
         // Clear, result and field load land together.
         cal_start <= 1'b0;
         cal_result <= cal_pass;
         if (cal_pass) begin
            pullup_strength <= cal_found;
         end else begin
            {pullup_strength, pullup_duty} <= `CAL_FAIL_LOAD;
         end
      end else begin
         if (cal_launch) begin
            cal_start <= 1'b1;
         end
         // Fields stay frozen while a calibration owns them; cal_result is written only on cal_done, never by software.
         if (wr_pcf && !cal_start) begin
            cal_port_select <= sfr_wdata[`PCF_CAL_PORT];
            pullup_strength <= sfr_wdata[`PCF_STRENGTH_HI:`PCF_STRENGTH_LO];
            pullup_duty <= sfr_wdata[`PCF_DUTY_HI:`PCF_DUTY_LO];
         end
      end
   end

   // ==========================================================================
   // Threshold configuration register and read-valid flag
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         high_threshold_sel <= 2'h0;
         low_threshold_sel <= 2'h0;
         force_pulldown <= 1'b0;
         force_pullup <= 1'b0;
      end else if (wr_th) begin
         high_threshold_sel <= sfr_wdata[`TH_HIGH_HI:`TH_HIGH_LO];
         low_threshold_sel <= sfr_wdata[`TH_LOW_HI:`TH_LOW_LO];
         force_pulldown <= sfr_wdata[`TH_FORCE_PD];
         force_pullup <= sfr_wdata[`TH_FORCE_PU];
      end
   end

   // An invalid read outranks the set-on-read and a software write, so it is never lost.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         read_ok_flag <= 1'b1;
      end else if ((rd_stat && (status_now != status_last)) || (ext_rt_rd && ext_rt_changed)) begin
         read_ok_flag <= 1'b0;
      end else if (rd_stat || ext_rt_rd) begin
         read_ok_flag <= 1'b1;
      end else if (rd_th) begin
         read_ok_flag <= 1'b1;
      end else if (wr_th) begin
         read_ok_flag <= sfr_wdata[`TH_READ_OK];
      end
   end

   // ==========================================================================
   // Status tracking
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         input_a_prior <= 1'b0;
         input_b_prior <= 1'b0;
      end else begin
         // Each prior bit holds the integrator value before its most recent change.
         if (integ_a != status_last.input_a) begin
            input_a_prior <= status_last.input_a;
         end
         if (integ_b != status_last.input_b) begin
            input_b_prior <= status_last.input_b;
         end
      end
   end

   // Quadrature position of {input_b, input_a}: LL=0, LH=1, HH=2, HL=3.
   function automatic logic [1:0] quad_pos(input logic b, input logic a);
      quad_pos = {b, b ^ a};
   endfunction

   logic [1:0] pos_now;
   assign pos_now = quad_pos(integ_b, integ_a);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pos_last <= 2'h0;
         direction <= 1'b0;
      end else begin
         pos_last <= pos_now;
         // Steps of two are quadrature errors and leave the direction alone.
         if (pos_now == pos_last + 2'h1) begin
            direction <= 1'b0;
         end else if (pos_now == pos_last - 2'h1) begin
            direction <= 1'b1;
         end
      end
   end

   always_comb begin
      status_now.flutter = quad_mode && flutter_raw;
      status_now.direction = quad_mode && direction;
      status_now.fsm_state = fsm_state;
      status_now.input_b_prior = input_b_prior;
      status_now.input_a_prior = input_a_prior;
      status_now.input_b = integ_b;
      status_now.input_a = integ_a;
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_last <= `RST_COUNTER_STATUS;
      end else begin
         status_last <= status_now;
      end
   end

   // ==========================================================================
   // Read data
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            `ADDR_COUNTER_STATUS: sfr_rdata <= status_now;
            `ADDR_PULLUP_CONFIG: sfr_rdata <= {cal_start, cal_result, cal_port_select,
                                               pullup_strength, pullup_duty};
            `ADDR_THRESHOLD_CONFIG: sfr_rdata <= {high_threshold_sel, low_threshold_sel,
                                                  force_pulldown, force_pullup, 1'b0,
                                                  read_ok_flag};
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ==========================================================================
   // Duty-cycled pull-up
   // On-time in frame cycles = frame * rate_num/16 * duty_num/8; worst case 90 of 128.
   logic [3:0] duty_num;
   logic [7:0] on_cycles;
   logic [7:0] frame_phase;
   logic duty_on;

   always_comb begin
      unique case (pullup_duty)
         2'h0: duty_num = 4'h2;
         2'h1: duty_num = 4'h3;
         2'h2: duty_num = 4'h4;
         2'h3: duty_num = 4'h6;
      endcase
   end

   assign on_cycles = 8'((16'(DUTY_FRAME) * rate_duty_num * duty_num) >> 7);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_phase <= 8'h00;
      end else if (frame_phase == 8'(DUTY_FRAME - 1)) begin
         frame_phase <= 8'h00;
      end else begin
         frame_phase <= frame_phase + 8'h01;
      end
   end

   assign duty_on = frame_phase < on_cycles;

   // ==========================================================================
   // Pin drive
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_drive <= '0;
      end else if (force_pulldown) begin
         pin_drive <= '{pullup_strength: `STRENGTH_OFF, pullup_on_a: 1'b0,
                        pullup_on_b: 1'b0, pulldown_on: 1'b1};
      end else if (cal_busy) begin
         pin_drive <= '{pullup_strength: cal_trial, pullup_on_a: !cal_port_select,
                        pullup_on_b: cal_port_select, pulldown_on: 1'b0};
      end else begin
         pin_drive.pullup_strength <= pullup_strength;
         pin_drive.pullup_on_a <= force_pullup || duty_on;
         pin_drive.pullup_on_b <= force_pullup || duty_on;
         pin_drive.pulldown_on <= 1'b0;
      end
   end

   // Nominal current in uA for the analog trim.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pullup_na <= 12'h000;
      end else begin
         unique case (pin_drive.pullup_strength)
            3'h0: pullup_na <= 12'h000;
            3'h1: pullup_na <= 12'h001;
            3'h2: pullup_na <= 12'h004;
            3'h3: pullup_na <= 12'h010;
            3'h4: pullup_na <= 12'h040;
            3'h5: pullup_na <= 12'h100;
            default: pullup_na <= 12'hFA0;
         endcase
      end
   end

   // ==========================================================================
   // Comparator thresholds, percent of io_supply
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         high_threshold_pct <= 7'h3B;
         low_threshold_pct <= 7'h2A;
      end else begin
         unique case (high_threshold_sel)
            2'h2: high_threshold_pct <= 7'h32;
            2'h3: high_threshold_pct <= 7'h37;
            2'h0: high_threshold_pct <= 7'h3B;
            2'h1: high_threshold_pct <= 7'h3F;
         endcase
         unique case (low_threshold_sel)
            2'h2: low_threshold_pct <= 7'h22;
            2'h3: low_threshold_pct <= 7'h26;
            2'h0: low_threshold_pct <= 7'h2A;
            2'h1: low_threshold_pct <= 7'h2E;
         endcase
      end
   end

endmodule

// ==== testbench/pulse_counter_asserts.sv ====
// Port-level checks for the pull-up, threshold and status block.
`timescale 1ns/100ps
module pulse_counter_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic ext_rt_rd,
   input wire logic ext_rt_changed,
   // Core state
   input wire logic quad_mode,
   input wire logic flutter_raw,
   input wire logic [1:0] fsm_state,
   input wire logic integ_a,
   input wire logic integ_b,
   // Drive and thresholds
   input wire pulse_counter_pkg::pin_drive_s pin_drive,
   input wire logic [6:0] high_threshold_pct,
   input wire logic [6:0] low_threshold_pct,
   input wire logic [11:0] pullup_na
);
   // ==========================================================================
   // Helpers
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   localparam logic [11:0] NA_TAB [8] = '{12'h000, 12'h001, 12'h004, 12'h010, 12'h040,
      12'h100, 12'hFA0, 12'hFA0};
   logic st_rd;
   logic th_rd;
   assign st_rd = sfr_rd && sfr_addr == 8'hC1;
   assign th_rd = sfr_rd && sfr_addr == 8'hE4 && !sfr_wr;
   // ==========================================================================
   // Assertions
   pd_wins_a:
      assert property (pin_drive.pulldown_on |-> !pin_drive.pullup_on_a && !pin_drive.pullup_on_b)
      else $error("pull-up on while pull-down forced");
   pd_forced_a:
      assert property (sfr_wr && sfr_addr == 8'hE4 && sfr_wdata[3] |-> ##[1:2] pin_drive.pulldown_on)
      else $error("forced pull-down not applied");
   status_now_a:
      assert property (st_rd |=> sfr_rdata[1:0] == $past({integ_b, integ_a}))
      else $error("current integrator bits wrong");
   state_field_a:
      assert property (st_rd |=> sfr_rdata[5:4] == $past(fsm_state))
      else $error("state field wrong");
   flutter_gate_a:
      assert property (st_rd |=> sfr_rdata[7] == $past(flutter_raw && quad_mode))
      else $error("flutter bit wrong");
   strength_current_a:
      assert property (pin_drive.pullup_on_a |=> pullup_na == NA_TAB[$past(pin_drive.pullup_strength)])
      else $error("pull-up current does not match strength");
   thresh_legal_a:
      assert property (high_threshold_pct inside {7'h32, 7'h37, 7'h3B, 7'h3F} &&
         low_threshold_pct inside {7'h22, 7'h26, 7'h2A, 7'h2E})
      else $error("threshold percent outside table");
   set_on_read_a:
      assert property (th_rd && !(ext_rt_rd && ext_rt_changed) ##1 th_rd |=> sfr_rdata[0])
      else $error("read valid flag not set by read");
   invalid_read_a:
      assert property (ext_rt_rd && ext_rt_changed && !sfr_wr ##1 th_rd |=> !sfr_rdata[0])
      else $error("changed read not reported invalid");
   cover property (sfr_wr && sfr_addr == 8'hD7 && sfr_wdata[7]);
   cover property (st_rd);
   cover property (ext_rt_rd && ext_rt_changed);
endmodule

bind pulse_counter_pullup_status pulse_counter_asserts i_chk (.ref_clk(ref_clk), .rst_b(rst_b),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
   .sfr_rdata(sfr_rdata), .ext_rt_rd(ext_rt_rd), .ext_rt_changed(ext_rt_changed),
   .quad_mode(quad_mode), .flutter_raw(flutter_raw), .fsm_state(fsm_state), .integ_a(integ_a),
   .integ_b(integ_b), .pin_drive(pin_drive), .high_threshold_pct(high_threshold_pct),
   .low_threshold_pct(low_threshold_pct), .pullup_na(pullup_na));

// ==== testbench/reed_pair_model.sv ====
// Two reed switches on the pulse inputs, sensed through the block's pin drive.
`timescale 1ns/100ps
module reed_pair_model (
   // Clock
   input wire logic ref_clk,
   // Drive from the block
   input wire pulse_counter_pkg::pin_drive_s pin_drive,
   // Switch state and weakest strength that lifts each line
   input wire logic closed_a,
   input wire logic closed_b,
   input wire logic [2:0] need_a,
   input wire logic [2:0] need_b,
   // Comparator levels
   output logic sense_a,
   output logic sense_b
);
   logic drift = 1'b0;
   // An unpulled line floats, so it wanders rather than keeping its last level.
   always @(posedge ref_clk) drift <= !drift;
   always_comb begin
      sense_a = pin_drive.pullup_on_a ? !closed_a && pin_drive.pullup_strength >= need_a : drift;
      sense_b = pin_drive.pullup_on_b ? !closed_b && pin_drive.pullup_strength >= need_b : drift;
      if (pin_drive.pulldown_on) begin
         sense_a = 1'b0;
         sense_b = 1'b0;
      end
   end
endmodule

// ==== testbench/pulse_counter_pullup_status_test.sv ====
// Self-checking bench for the pull-up, threshold, read-valid and status block.
`timescale 1ns/100ps
module pulse_counter_pullup_status_test;
   // ==========================================================================
   // Signals
   localparam int FRAME = 32;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic ext_rt_rd = 1'b0;
   logic ext_rt_changed = 1'b0;
   logic quad_mode = 1'b0;
   logic flutter_raw = 1'b0;
   logic [1:0] fsm_state = 2'h2;
   logic integ_a = 1'b0;
   logic integ_b = 1'b0;
   logic [3:0] rate_duty_num = 4'h8;
   logic sense_a;
   logic sense_b;
   logic closed_b = 1'b0;
   logic [2:0] need_b = 3'h2;
   pulse_counter_pkg::pin_drive_s pin_drive;
   logic [6:0] high_threshold_pct;
   logic [6:0] low_threshold_pct;
   logic [11:0] pullup_na;
   int errors = 0;
   int cmp_count = 0;
   always #4 ref_clk = !ref_clk;
   pulse_counter_pullup_status #(.SETTLE_CYCLES(4), .DUTY_FRAME(FRAME)) i_dut (.ref_clk(ref_clk),
      .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .ext_rt_rd(ext_rt_rd), .ext_rt_changed(ext_rt_changed),
      .quad_mode(quad_mode), .flutter_raw(flutter_raw), .fsm_state(fsm_state), .integ_a(integ_a),
      .integ_b(integ_b), .rate_duty_num(rate_duty_num), .sense_a(sense_a), .sense_b(sense_b),
      .pin_drive(pin_drive), .high_threshold_pct(high_threshold_pct),
      .low_threshold_pct(low_threshold_pct), .pullup_na(pullup_na));
   reed_pair_model i_reeds (.ref_clk(ref_clk), .pin_drive(pin_drive), .closed_a(1'b0),
      .closed_b(closed_b), .need_a(3'h3), .need_b(need_b), .sense_a(sense_a), .sense_b(sense_b));
   // ==========================================================================
   // Bus and compare tasks
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(12'(v), 12'(e));
   endtask
   task automatic step(input logic b, input logic a);
      integ_b = b;
      integ_a = a;
      repeat (3) @(negedge ref_clk);
   endtask
   // ==========================================================================
   // Scenarios
   task automatic t_thresholds;
      logic [6:0] hi [4] = '{7'h3B, 7'h3F, 7'h32, 7'h37};
      logic [6:0] lo [4] = '{7'h2A, 7'h2E, 7'h22, 7'h26};
      rdchk(8'hD7, 8'h44);
      rdchk(8'hE4, 8'h01);
      for (int c = 3; c >= 0; c--) begin
         wr(8'hE4, {c[1:0], c[1:0], 4'h1});
         repeat (2) @(negedge ref_clk);
         chk(12'(high_threshold_pct), 12'(hi[c]));
         chk(12'(low_threshold_pct), 12'(lo[c]));
      end
   endtask
   task automatic t_force;
      wr(8'hE4, 8'h09);
      repeat (2) @(negedge ref_clk);
      chk(12'(pin_drive), 12'h001);
      wr(8'hE4, 8'h0D);
      repeat (2) @(negedge ref_clk);
      chk(12'(pin_drive), 12'h001);
      wr(8'hE4, 8'h07);
      repeat (FRAME + 2) @(negedge ref_clk) chk(12'(pin_drive), 12'h00E);
      rdchk(8'hE4, 8'h05);
      wr(8'hE4, 8'h01);
   endtask
   task automatic t_duty;
      logic [11:0] n;
      logic [11:0] on [5] = '{12'h004, 12'h006, 12'h008, 12'h00C, 12'h004};
      for (int c = 0; c < 5; c++) begin
         if (c == 4) rate_duty_num = 4'h4;
         wr(8'hD7, {6'h01, c == 4 ? 2'h2 : c[1:0]});
         repeat (2 * FRAME) @(negedge ref_clk);
         n = 12'h000;
         repeat (FRAME) @(negedge ref_clk) n += 12'(pin_drive.pullup_on_a);
         chk(n, on[c]);
      end
   endtask
   task automatic t_status;
      flutter_raw = 1'b1;
      step(1'b0, 1'b1);
      step(1'b1, 1'b0);
      rdchk(8'hC1, 8'h26);
      quad_mode = 1'b1;
      flutter_raw = 1'b0;
      step(1'b0, 1'b0);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      rdchk(8'hC1, 8'h23);
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      wr(8'hC1, 8'hFF);
      rdchk(8'hC1, 8'h66);
      flutter_raw = 1'b1;
      rdchk(8'hC1, 8'hE6);
      quad_mode = 1'b0;
      rdchk(8'hC1, 8'h26);
   endtask
   task automatic t_valid;
      @(negedge ref_clk);
      sfr_addr = 8'hC1;
      sfr_rd = 1'b1;
      integ_a = 1'b1;
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      rdchk(8'hE4, 8'h00);
      rdchk(8'hC1, 8'h23);
      rdchk(8'hE4, 8'h01);
      @(negedge ref_clk);
      ext_rt_rd = 1'b1;
      ext_rt_changed = 1'b1;
      @(negedge ref_clk);
      ext_rt_rd = 1'b0;
      ext_rt_changed = 1'b0;
      sfr_addr = 8'hE4;
      sfr_rd = 1'b1;
      @(negedge ref_clk);
      chk(12'(sfr_rdata), 12'h000);
      @(negedge ref_clk);
      sfr_rd = 1'b0;
      chk(12'(sfr_rdata), 12'h001);
      @(negedge ref_clk);
      ext_rt_rd = 1'b1;
      @(negedge ref_clk);
      ext_rt_rd = 1'b0;
      rdchk(8'hE4, 8'h01);
   endtask
   task automatic cal(input logic [7:0] cmd, input logic [7:0] e);
      logic [7:0] v;
      wr(8'hD7, cmd);
      repeat (2) @(negedge ref_clk);
      chk(12'({pin_drive.pullup_on_a, pin_drive.pullup_on_b}), cmd[5] ? 12'h001 : 12'h002);
      v = 8'h80;
      for (int i = 0; i < 100 && v[7] !== 1'b0; i++) rd(8'hD7, v);
      chk(12'(v), 12'(e));
   endtask
   task automatic t_cal;
      cal(8'h85, 8'h4D);
      cal(8'hA1, 8'h69);
      wr(8'hD7, 8'h09);
      rdchk(8'hD7, 8'h49);
      closed_b = 1'b1;
      cal(8'hA5, 8'h3F);
      repeat (2) @(negedge ref_clk);
      chk(pullup_na, 12'hFA0);
   endtask
   // ==========================================================================
   // Sequence, watchdog and verdict
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge ref_clk);
      rst_b = 1'b1;
      t_thresholds;
      t_force;
      t_duty;
      t_status;
      t_valid;
      t_cal;
      test_done;
   end
   initial begin
      #(8 * 6000);
      errors++;
      test_done;
   end
endmodule
